// ==== pkg/ledreg_cfg.svh ====
`ifndef LEDREG_CFG_SVH
`define LEDREG_CFG_SVH
`define LEDREG_ADDR_FAULT_A 5'h00
`define LEDREG_ADDR_FAULT_B 5'h01
`define LEDREG_ADDR_BANK_SEL 5'h03
`define LEDREG_ADDR_LATCH 5'h04
`define LEDREG_ADDR_WIN_X 5'h05
`define LEDREG_ADDR_WIN_Y 5'h06
`define LEDREG_ADDR_WIN_Z 5'h07
`define LEDREG_BANK_HI 5'h03
`define LEDREG_LATCH_KEY 8'h00
`define LEDREG_FAULT_RESET 8'h00
`define LEDREG_A_LATCH_MASK 8'h3F
`define LEDREG_A_STATUS_MASK 8'h40
`define LEDREG_B_LATCH_MASK 8'hB4
`define LEDREG_B_STATUS_MASK 8'h43
`define LEDREG_SUMMARY_BIT 7
`define LEDREG_A_OUT_OV 5
`define LEDREG_A_OUT_UV 4
`define LEDREG_A_OUT_OC 3
`define LEDREG_A_OPEN 2
`define LEDREG_A_STR_SHORT 0
`define LEDREG_B_HIGH_BEAM 5
`define LEDREG_B_RESERVED 3
`define LEDREG_B_REG_LOW 1
`define LEDREG_B_OVER_TEMP 0
`define LEDREG_CFG_COUNT 23
`define LEDREG_CFG_LIMITS 1
`define LEDREG_CFG_BIN_A 2
`define LEDREG_CFG_BIN_B 3
`define LEDREG_CFG_SUPPLY_A 9
`define LEDREG_CFG_SUPPLY_GT 13
`define LEDREG_CFG_BEAM 16
`define LEDREG_CFG_ROUTE_A 21
`define LEDREG_CFG_ROUTE_B 22
`define LEDREG_RST_CFG0 8'h08
`define LEDREG_RST_CFG1 8'hF0
`define LEDREG_RST_CFG2 8'h50
`define LEDREG_RST_CFG3 8'hCF
`define LEDREG_RST_CFG4 8'h26
`define LEDREG_RST_CFG5 8'h0E
`define LEDREG_RST_CFG6 8'h08
`define LEDREG_RST_CFG7 8'h03
`define LEDREG_RST_CFG8 8'h00
`define LEDREG_RST_CFG9 8'h07
`define LEDREG_RST_CFG10 8'h05
`define LEDREG_RST_CFG11 8'h02
`define LEDREG_RST_CFG12 8'h01
`define LEDREG_RST_CFG13 8'h13
`define LEDREG_RST_CFG14 8'h00
`define LEDREG_RST_CFG15 8'h00
`define LEDREG_RST_CFG16 8'h00
`define LEDREG_RST_CFG17 8'h1F
`define LEDREG_RST_CFG18 8'h1F
`define LEDREG_RST_CFG19 8'h00
`define LEDREG_RST_CFG20 8'h00
`define LEDREG_RST_CFG21 8'h1F
`define LEDREG_RST_CFG22 8'h03
`define LEDREG_CFG_RESET {`LEDREG_RST_CFG22, `LEDREG_RST_CFG21, `LEDREG_RST_CFG20, `LEDREG_RST_CFG19, \
	`LEDREG_RST_CFG18, `LEDREG_RST_CFG17, `LEDREG_RST_CFG16, `LEDREG_RST_CFG15, `LEDREG_RST_CFG14, \
	`LEDREG_RST_CFG13, `LEDREG_RST_CFG12, `LEDREG_RST_CFG11, `LEDREG_RST_CFG10, `LEDREG_RST_CFG9, \
	`LEDREG_RST_CFG8, `LEDREG_RST_CFG7, `LEDREG_RST_CFG6, `LEDREG_RST_CFG5, `LEDREG_RST_CFG4, \
	`LEDREG_RST_CFG3, `LEDREG_RST_CFG2, `LEDREG_RST_CFG1, `LEDREG_RST_CFG0}
`endif

// ==== pkg/ledreg_pkg.sv ====
`include "ledreg_cfg.svh"
package ledreg_pkg;
	typedef logic [7:0] ledreg_byte_t;
	typedef logic [4:0] ledreg_addr_t;
	typedef logic [2:0][7:0] ledreg_bank_t;
	typedef logic [`LEDREG_CFG_COUNT-1:0][7:0] ledreg_cfg_t;
	typedef struct packed {
		ledreg_cfg_t cfg;
		ledreg_bank_t rd_data;
	} ledreg_mem_st_t;
	typedef struct packed {
		ledreg_byte_t a;
		ledreg_byte_t b;
	} ledreg_fault_st_t;
	typedef struct packed {
		ledreg_byte_t bank_idx;
		logic bank_ok;
		logic load_pend;
		ledreg_bank_t win;
		ledreg_byte_t rdata;
		logic rvalid;
		logic pin2;
	} ledreg_main_st_t;
endpackage : ledreg_pkg

// ==== pkg/ledreg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface ledreg_if;
	import ledreg_pkg::*;
	logic rd_en;
	logic [2:0] rd_bank;
	ledreg_bank_t rd_data;
	logic wr_en;
	logic [2:0] wr_bank;
	ledreg_bank_t wr_data;
	ledreg_cfg_t cfg;
	ledreg_byte_t cond_a;
	ledreg_byte_t cond_b;
	ledreg_byte_t clr_a;
	ledreg_byte_t clr_b;
	ledreg_byte_t flt_a;
	ledreg_byte_t flt_b;
	modport ctl (output rd_en, rd_bank, wr_en, wr_bank, wr_data, cond_a, cond_b, clr_a, clr_b,
		input rd_data, cfg, flt_a, flt_b);
	modport mem (input rd_en, rd_bank, wr_en, wr_bank, wr_data, output rd_data, cfg);
	modport fault (input cond_a, cond_b, clr_a, clr_b, output flt_a, flt_b);
endinterface : ledreg_if
`default_nettype wire

// ==== hw/ledreg_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ledreg_cfg.svh"
module ledreg_mem (
	input wire logic clock,
	input wire logic rst_n,
	ledreg_if.mem bus
);
	import ledreg_pkg::*;
	ledreg_mem_st_t st_reg;
	ledreg_mem_st_t st_next;
	ledreg_cfg_t cfg_upd;
	genvar k;
	// bank b holds entries 3b (slot 0), 3b+1 (slot 1), 3b+2 (slot 2)
	generate
		for (k = 0; k < `LEDREG_CFG_COUNT; k++)
		begin : g_entry
			assign cfg_upd[k] = (bus.wr_en && bus.wr_bank == 3'(k / 3)) ? bus.wr_data[k % 3] : st_reg.cfg[k];
		end
	endgenerate
	always_comb
	begin
		int idx;
		idx = 0;
		st_next = st_reg;
		st_next.cfg = cfg_upd;
		if (bus.rd_en)
		begin
			for (int s = 0; s < 3; s++)
			begin
				idx = 3 * int'(bus.rd_bank) + s;
				st_next.rd_data[s] = (idx < `LEDREG_CFG_COUNT) ? st_reg.cfg[5'(idx)] : 8'h00;
			end
		end
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_reg.cfg <= `LEDREG_CFG_RESET;
			st_reg.rd_data <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
	assign bus.cfg = st_reg.cfg;
	assign bus.rd_data = st_reg.rd_data;
endmodule : ledreg_mem
`default_nettype wire

// ==== hw/ledreg_fault.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ledreg_cfg.svh"
module ledreg_fault (
	input wire logic clock,
	input wire logic rst_n,
	ledreg_if.fault bus
);
	import ledreg_pkg::*;
	localparam logic [15:0] LATCH_M = {`LEDREG_B_LATCH_MASK, `LEDREG_A_LATCH_MASK};
	localparam logic [15:0] STATUS_M = {`LEDREG_B_STATUS_MASK, `LEDREG_A_STATUS_MASK};
	ledreg_fault_st_t st_reg;
	ledreg_fault_st_t st_next;
	logic [15:0] cond;
	logic [15:0] clr;
	logic [15:0] cur;
	logic [15:0] bit_n;
	assign cond = {bus.cond_b, bus.cond_a};
	assign clr = {bus.clr_b, bus.clr_a};
	assign cur = {st_reg.b, st_reg.a};
	genvar i;
	generate
		for (i = 0; i < 16; i++)
		begin : g_bit
			// live fault wins over a clearing write; masks drop summary/reserved/status writes
			assign bit_n[i] = STATUS_M[i] ? cond[i] :
				LATCH_M[i] ? (cond[i] | (cur[i] & ~clr[i])) : 1'b0;
		end
	endgenerate
	always_comb
	begin
		st_next.b = bit_n[15:8];
		st_next.a = {|{bit_n[15:8], bit_n[6:0]}, bit_n[6:0]};
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_reg.a <= `LEDREG_FAULT_RESET;
			st_reg.b <= `LEDREG_FAULT_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
	assign bus.flt_a = st_reg.a;
	assign bus.flt_b = st_reg.b;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_summary_flag: assert property (st_reg.a[7] == |{st_reg.b, st_reg.a[6:0]})
		else $error("summary flag disagrees with fault bits");
	a_latch_hold: assert property ((cur & LATCH_M & ~clr) != 16'h0000 |=>
		(cur & $past(cur & LATCH_M & ~clr)) == $past(cur & LATCH_M & ~clr))
		else $error("latched fault dropped without clear");
	a_clear_works: assert property (((cur & LATCH_M & clr & ~cond) != 16'h0000) ##1 (cond == 16'h0000) |->
		(cur & $past(cur & LATCH_M & clr & ~cond)) == 16'h0000)
		else $error("write one did not clear fault");
	a_clear_blocked: assert property ((LATCH_M & clr & cond) != 16'h0000 |=>
		(cur & $past(LATCH_M & clr & cond)) == $past(LATCH_M & clr & cond))
		else $error("active fault cleared by write");
	a_status_follow: assert property (##1 (cur & STATUS_M) == ($past(cond) & STATUS_M))
		else $error("status bit not following condition");
	a_reserved_zero: assert property (st_reg.b[`LEDREG_B_RESERVED] == 1'b0)
		else $error("reserved fault bit set");
	c_clear_blocked: cover property ((LATCH_M & clr & cond) != 16'h0000);
endmodule : ledreg_fault
`default_nettype wire

// ==== hw/ledreg_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ledreg_cfg.svh"
module ledreg_bank (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire ledreg_pkg::ledreg_addr_t reg_addr,
	input wire ledreg_pkg::ledreg_byte_t reg_wdata,
	input wire ledreg_pkg::ledreg_byte_t fault_cond_a,
	input wire ledreg_pkg::ledreg_byte_t fault_cond_b,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic summary_fault_flag,
	output logic second_fault_pin,
	output ledreg_pkg::ledreg_cfg_t setup_regs
);
	import ledreg_pkg::*;

	ledreg_if u_if ();

	ledreg_mem u_mem (
		.clock(clock),
		.rst_n(rst_n),
		.bus(u_if.mem)
	);

	ledreg_fault u_fault (
		.clock(clock),
		.rst_n(rst_n),
		.bus(u_if.fault)
	);

	ledreg_main_st_t st_reg;
	ledreg_main_st_t st_next;
	logic wr_fault_a;
	logic wr_fault_b;
	logic wr_bank_sel;
	logic wr_latch;
	logic bank_valid;
	logic [5:0] route_src_a;
	logic [1:0] route_src_b;
	logic route_hit;

	assign wr_fault_a = reg_wr && reg_addr == `LEDREG_ADDR_FAULT_A;
	assign wr_fault_b = reg_wr && reg_addr == `LEDREG_ADDR_FAULT_B;
	assign wr_bank_sel = reg_wr && reg_addr == `LEDREG_ADDR_BANK_SEL;
	assign wr_latch = reg_wr && reg_addr == `LEDREG_ADDR_LATCH;
	// only indices 0x18..0x1F name a setup bank
	assign bank_valid = reg_wdata[7:3] == `LEDREG_BANK_HI;

	// fault side
	assign u_if.cond_a = fault_cond_a;
	assign u_if.cond_b = fault_cond_b;
	assign u_if.clr_a = wr_fault_a ? reg_wdata : 8'h00;
	assign u_if.clr_b = wr_fault_b ? reg_wdata : 8'h00;

	// bank read is issued in the same cycle as the select write
	assign u_if.rd_en = wr_bank_sel && bank_valid;
	assign u_if.rd_bank = reg_wdata[2:0];

	// commit only on the documented key and a valid selection
	assign u_if.wr_en = wr_latch && reg_wdata == `LEDREG_LATCH_KEY && st_reg.bank_ok;
	assign u_if.wr_bank = st_reg.bank_idx[2:0];
	assign u_if.wr_data = st_reg.win;

	// faults steered to the second fault pin
	assign route_src_a = {
		u_if.flt_b[`LEDREG_B_REG_LOW],
		u_if.flt_a[`LEDREG_A_OUT_OV],
		u_if.flt_a[`LEDREG_A_OUT_UV],
		u_if.flt_a[`LEDREG_A_OUT_OC],
		u_if.flt_a[`LEDREG_A_OPEN],
		u_if.flt_a[`LEDREG_A_STR_SHORT]
	};
	assign route_src_b = {
		u_if.flt_b[`LEDREG_B_HIGH_BEAM],
		u_if.flt_b[`LEDREG_B_OVER_TEMP]
	};
	assign route_hit = |(route_src_a & u_if.cfg[`LEDREG_CFG_ROUTE_A][5:0])
		| |(route_src_b & u_if.cfg[`LEDREG_CFG_ROUTE_B][1:0]);

	always_comb
	begin
		st_next = st_reg;
		st_next.load_pend = 1'b0;
		st_next.rvalid = 1'b0;
		st_next.pin2 = route_hit;
		if (wr_bank_sel)
		begin
			st_next.bank_idx = reg_wdata;
			st_next.bank_ok = bank_valid;
			st_next.load_pend = bank_valid;
			if (!bank_valid)
			begin
				st_next.win = '0;
			end
		end
		// copy the selected bank into the windows
		if (st_reg.load_pend)
		begin
			st_next.win = u_if.rd_data;
		end
		// a window write after the select wins over the copy
		if (reg_wr)
		begin
			case (reg_addr)
				`LEDREG_ADDR_WIN_X:
				begin
					st_next.win[2] = reg_wdata;
				end
				`LEDREG_ADDR_WIN_Y:
				begin
					st_next.win[1] = reg_wdata;
				end
				`LEDREG_ADDR_WIN_Z:
				begin
					st_next.win[0] = reg_wdata;
				end
				default:
				begin
					st_next.rvalid = 1'b0;
				end
			endcase
		end
		if (reg_rd)
		begin
			st_next.rvalid = 1'b1;
			case (reg_addr)
				`LEDREG_ADDR_FAULT_A:
				begin
					st_next.rdata = u_if.flt_a;
				end
				`LEDREG_ADDR_FAULT_B:
				begin
					st_next.rdata = u_if.flt_b;
				end
				`LEDREG_ADDR_BANK_SEL:
				begin
					st_next.rdata = st_reg.bank_idx;
				end
				`LEDREG_ADDR_WIN_X:
				begin
					st_next.rdata = st_reg.win[2];
				end
				`LEDREG_ADDR_WIN_Y:
				begin
					st_next.rdata = st_reg.win[1];
				end
				`LEDREG_ADDR_WIN_Z:
				begin
					st_next.rdata = st_reg.win[0];
				end
				default:
				begin
					st_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_reg.bank_idx <= 8'h00;
			st_reg.bank_ok <= 1'b0;
			st_reg.load_pend <= 1'b0;
			st_reg.win <= '0;
			st_reg.rdata <= 8'h00;
			st_reg.rvalid <= 1'b0;
			st_reg.pin2 <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign summary_fault_flag = u_if.flt_a[`LEDREG_SUMMARY_BIT];
	assign second_fault_pin = st_reg.pin2;
	assign setup_regs = u_if.cfg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_limits_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_LIMITS] == `LEDREG_RST_CFG1)
		else $error("input limit setup reset wrong");

	a_bin_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_BIN_A] == `LEDREG_RST_CFG2
		&& setup_regs[`LEDREG_CFG_BIN_B] == `LEDREG_RST_CFG3)
		else $error("binning setup reset wrong");

	a_supply_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_SUPPLY_A] == `LEDREG_RST_CFG9
		&& setup_regs[`LEDREG_CFG_SUPPLY_GT] == `LEDREG_RST_CFG13)
		else $error("supply foldback reset wrong");

	a_beam_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_BEAM] == `LEDREG_RST_CFG16)
		else $error("beam control reset wrong");

	a_route_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_ROUTE_A] == `LEDREG_RST_CFG21)
		else $error("routing a reset wrong");

	a_route_b_reset: assert property (!$past(rst_n) |-> setup_regs[`LEDREG_CFG_ROUTE_B] == `LEDREG_RST_CFG22)
		else $error("routing b reset wrong");

	a_pin_follows: assert property (##1 second_fault_pin == $past(route_hit))
		else $error("second fault pin not following routed faults");

	a_read_fault_a: assert property (reg_rd && reg_addr == `LEDREG_ADDR_FAULT_A |=> reg_rvalid
		&& reg_rdata == $past(u_if.flt_a))
		else $error("fault register a read wrong");

	a_read_fault_b: assert property (reg_rd && reg_addr == `LEDREG_ADDR_FAULT_B |=> reg_rvalid
		&& reg_rdata == $past(u_if.flt_b) && reg_rdata[`LEDREG_B_RESERVED] == 1'b0)
		else $error("fault register b read wrong");

	a_commit_bank: assert property (u_if.wr_en && st_reg.bank_idx[2:0] == 3'h1 |=>
		setup_regs[5:3] == $past(st_reg.win))
		else $error("latch write did not commit bank");

	a_commit_key: assert property (wr_latch && reg_wdata != `LEDREG_LATCH_KEY |=> $stable(setup_regs))
		else $error("setup changed without latch key");

	a_bank_load: assert property (wr_bank_sel && bank_valid ##1 !reg_wr |=>
		st_reg.win == $past(u_if.rd_data))
		else $error("window not loaded from selected bank");

	c_bank_load: cover property (wr_bank_sel && bank_valid ##2 reg_rd);
	c_commit: cover property (u_if.wr_en);
	c_clear_all: cover property (wr_fault_a && reg_wdata == 8'hFF ##2 wr_fault_b && reg_wdata == 8'hFF);
	c_pin_rise: cover property ($rose(second_fault_pin));
endmodule : ledreg_bank
`default_nettype wire

// ==== verification/ledreg_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ledreg_cfg.svh"
module ledreg_host (
	input wire logic clock,
	output logic reg_wr,
	output logic reg_rd,
	output ledreg_pkg::ledreg_addr_t reg_addr,
	output ledreg_pkg::ledreg_byte_t reg_wdata,
	input wire ledreg_pkg::ledreg_byte_t reg_rdata,
	input wire logic reg_rvalid
);
	import ledreg_pkg::*;
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
	end
	// released lines show the inverse of the last value
	task automatic wr_reg(input ledreg_addr_t a, input ledreg_byte_t d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr_reg
	task automatic rd_reg(input ledreg_addr_t a, output ledreg_byte_t d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
	endtask : rd_reg
	task automatic sel_bank(input logic [2:0] b);
		wr_reg(`LEDREG_ADDR_BANK_SEL, {5'h03, b});
	endtask : sel_bank
	task automatic commit;
		wr_reg(`LEDREG_ADDR_LATCH, `LEDREG_LATCH_KEY);
	endtask : commit
	task automatic clear_all;
		wr_reg(`LEDREG_ADDR_FAULT_A, 8'hFF);
		wr_reg(`LEDREG_ADDR_FAULT_B, 8'hFF);
	endtask : clear_all
endmodule : ledreg_host
`default_nettype wire

// ==== verification/ledreg_bank_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ledreg_cfg.svh"
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); \
		end \
	end
module ledreg_bank_tb_top;
	import ledreg_pkg::*;
	localparam ledreg_addr_t FA = `LEDREG_ADDR_FAULT_A;
	localparam ledreg_addr_t FB = `LEDREG_ADDR_FAULT_B;
	localparam ledreg_addr_t LK = `LEDREG_ADDR_LATCH;
	localparam ledreg_addr_t WX = `LEDREG_ADDR_WIN_X;
	localparam ledreg_addr_t WY = `LEDREG_ADDR_WIN_Y;
	localparam ledreg_addr_t WZ = `LEDREG_ADDR_WIN_Z;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr;
	logic reg_rd;
	ledreg_addr_t reg_addr;
	ledreg_byte_t reg_wdata;
	ledreg_byte_t cond_a = 8'h00;
	ledreg_byte_t cond_b = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic summary_fault_flag;
	logic second_fault_pin;
	ledreg_cfg_t setup_regs;
	int error_cnt = 0;
	int total_checks = 0;
	int cycle_cnt = 0;
	always #12.5 clock = ~clock;
	ledreg_bank uut (
		.clock(clock),
		.rst_n(rst_n),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.fault_cond_a(cond_a),
		.fault_cond_b(cond_b),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.summary_fault_flag(summary_fault_flag),
		.second_fault_pin(second_fault_pin),
		.setup_regs(setup_regs)
	);
	ledreg_host host (
		.clock(clock),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid)
	);
	task automatic end_of_test;
		$display("checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic sc(input ledreg_byte_t a, input ledreg_byte_t b);
		@(negedge clock);
		cond_a = a;
		cond_b = b;
	endtask : sc
	task automatic w2;
		repeat (2) @(negedge clock);
	endtask : w2
	task automatic rc(input ledreg_addr_t a, input ledreg_byte_t e);
		ledreg_byte_t d;
		host.rd_reg(a, d);
		`CHK(d, e)
	endtask : rc
	task automatic t_reset;
		ledreg_cfg_t r;
		r = `LEDREG_CFG_RESET;
		`CHK(setup_regs[1], 8'hF0)
		`CHK({setup_regs[3], setup_regs[2]}, 16'hCF50)
		`CHK({setup_regs[13], setup_regs[9]}, 16'h1307)
		`CHK(setup_regs[16], 8'h00)
		`CHK(setup_regs[21], 8'h1F)
		`CHK(setup_regs[22], 8'h03)
		`CHK({summary_fault_flag, second_fault_pin}, 2'b00)
		rc(FA, 8'h00);
		rc(FB, 8'h00);
		rc(5'h02, 8'h00);
		for (int b = 0; b < 8; b++)
		begin
			host.sel_bank(3'(b));
			rc(WX, (b == 7) ? 8'h00 : r[3 * b + 2]);
			rc(WY, r[3 * b + 1]);
			rc(WZ, r[3 * b]);
		end
		rc(5'h03, 8'h1F);
	endtask : t_reset
	task automatic t_latch;
		sc(8'h04, 8'h00);
		w2;
		`CHK({summary_fault_flag, second_fault_pin}, 2'b11)
		sc(8'h00, 8'h00);
		rc(FA, 8'h84);
		host.wr_reg(FA, 8'h00);
		rc(FA, 8'h84);
		host.wr_reg(FA, 8'h04);
		`CHK(summary_fault_flag, 1'b0)
		rc(FA, 8'h00);
		`CHK(second_fault_pin, 1'b0)
	endtask : t_latch
	task automatic t_held;
		sc(8'h20, 8'h00);
		host.wr_reg(FA, 8'h20);
		rc(FA, 8'hA0);
		sc(8'h00, 8'h00);
		rc(FA, 8'hA0);
		host.wr_reg(FA, 8'h20);
		rc(FA, 8'h00);
	endtask : t_held
	task automatic t_status;
		sc(8'h40, 8'h43);
		w2;
		rc(FA, 8'hC0);
		rc(FB, 8'h43);
		host.clear_all;
		rc(FA, 8'hC0);
		sc(8'h00, 8'h02);
		w2;
		`CHK({summary_fault_flag, second_fault_pin}, 2'b10)
		rc(FA, 8'h80);
		sc(8'h00, 8'h00);
		w2;
		rc(FB, 8'h00);
		`CHK(summary_fault_flag, 1'b0)
	endtask : t_status
	task automatic t_layout_b;
		sc(8'h00, 8'hFF);
		w2;
		rc(FB, 8'hF7);
		`CHK(second_fault_pin, 1'b1)
		sc(8'h00, 8'h00);
		w2;
		rc(FB, 8'hB4);
		rc(FA, 8'h80);
		host.clear_all;
		rc(FB, 8'h00);
		`CHK(summary_fault_flag, 1'b0)
	endtask : t_layout_b
	task automatic t_banked;
		host.sel_bank(3'd1);
		host.wr_reg(WX, 8'h15);
		host.wr_reg(WY, 8'h45);
		host.wr_reg(WZ, 8'hA3);
		`CHK(setup_regs[5], 8'h0E)
		host.wr_reg(LK, 8'h01);
		`CHK(setup_regs[5], 8'h0E)
		host.commit;
		`CHK(setup_regs[5:3], 24'h1545A3)
		rc(WX, 8'h15);
		host.sel_bank(3'd5);
		host.wr_reg(WY, 8'h0D);
		host.commit;
		`CHK(setup_regs[16], 8'h0D)
		host.sel_bank(3'd7);
		host.wr_reg(WY, 8'h00);
		host.commit;
		sc(8'h00, 8'h20);
		w2;
		`CHK({summary_fault_flag, second_fault_pin}, 2'b10)
		sc(8'h00, 8'h00);
		host.clear_all;
		rc(FB, 8'h00);
	endtask : t_banked
	always @(posedge clock)
	begin
		cycle_cnt++;
		if (cycle_cnt == 3000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_latch();
		t_held();
		t_status();
		t_layout_b();
		t_banked();
		end_of_test();
	end
endmodule : ledreg_bank_tb_top
`default_nettype wire
